// [npw_pins_model.sv]
// Purpose: board-side model of the eight port pins
// Assumes: ext_en_i bits drive ext_val_i where the port does not drive
// Notes:   an undriven pin without pull-up flips every cycle
`timescale 1ns/1ps
module npw_pins_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] lvl_o
);
    logic [7:0] flt = 8'h00;
    always_ff @(posedge clk_i) begin
        flt <= ~flt;
    end
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (oe_i[b]) lvl_o[b] = drv_i[b];
            else if (ext_en_i[b]) lvl_o[b] = ext_val_i[b];
            else if (pu_i[b]) lvl_o[b] = 1'b1;
            else lvl_o[b] = flt[b];
        end
    end
endmodule // npw_pins_model

// [npw_pkg.sv]
// Purpose: types shared by the port design
// Assumes: nothing beyond the register header
// Notes:   constants live in npw_port_regs.svh
package npw_pkg;

    // ----------------------------------------------------------------
    // clock output enable state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        NPW_CKO_OFF   = 2'b00,
        NPW_CKO_ON    = 2'b01,
        NPW_CKO_DRAIN = 2'b10
    } npw_cko_state_t;

    // divider code selecting the clock output source
    typedef logic [2:0] npw_div_code_t;

endpackage

// [npw_port.sv]
// Purpose: eight-pin port with nibble direction/pull-up control, low-level wake flag
//          and timer/clock alternate outputs, reached over classic Wishbone
// Assumes: Wishbone word addressing on adr_i[17:2], byte lane 0 carries register data;
//          src_osc_i and sub_osc_i are slow clocks sampled as pin inputs
// Notes:   pins are split into input, output and output enable
`timescale 1ns/1ps
`include "npw_port_regs.svh"

// Notes on behaviour
// - each output-mode pin is driven from its own bit of the eight-bit latch
// - a plain latch read returns pin levels, not the stored latch
// - set, clear, invert and raw access act on the stored latch value
// - pin levels read through the latch register whatever the direction
// - upper direction bit 1 makes pins seven to four outputs, else inputs
// - lower direction bit 1 makes pins three to zero outputs, else inputs
// - flag sets when an input pin is low while its latch bit is 1
// - flag and enable both 1 raise standby release and interrupt at 004BH
// - upper pull-ups on only with enable 1, direction 0, push-pull option
// - lower pull-ups on only with enable 1, direction 0, push-pull option
// - upper strength select 1 picks high-impedance pull-ups, 0 low-impedance
// - lower strength select 1 picks high-impedance pull-ups, 0 low-impedance
// - pin seven output ORs timer-seven toggle into latch when enabled
// - pin six output ORs timer-six toggle into latch when enabled
// - pin five output ORs divided clock into latch when enabled, outputs only
// - divider codes 000..110 give source over 1..64, 111 gives subclock
// - clearing clock output enable takes effect at the output clock's falling edge
// - idle and deep standby freeze every pin state held at entry
module npw_port
    import npw_pkg::*;
#(
    parameter logic [7:0] CMOS_OPTION = 8'hff,
    parameter int         DIV_WIDTH   = `NPW_DIV_BITS
) (
    input  wire  logic        clk_i,
    input  wire  logic        rst_i,
    input  wire  logic        cyc_i,
    input  wire  logic        stb_i,
    input  wire  logic        we_i,
    input  wire  logic [17:0] adr_i,
    input  wire  logic [3:0]  sel_i,
    input  wire  logic [31:0] dat_i,
    output logic       [31:0] dat_o,
    output logic              ack_o,
    input  wire  logic [7:0]  pin_i,
    output logic       [7:0]  pin_o,
    output logic       [7:0]  pin_oe_o,
    output logic       [7:0]  pullup_en_o,
    output logic       [7:0]  pullup_hiz_o,
    input  wire  logic        timer6_toggle_i,
    input  wire  logic        timer7_toggle_i,
    input  wire  logic        src_osc_i,
    input  wire  logic        sub_osc_i,
    input  wire  logic        idle_i,
    input  wire  logic        standby_i,
    output logic              irq_o,
    output logic       [7:0]  irq_vector_o,
    output logic              standby_release_o
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    generate
        if (DIV_WIDTH != `NPW_DIV_BITS) begin : g_bad_div
            $error("npw_port: DIV_WIDTH must be 6 to serve codes up to 1/64");
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]           port_output_latch;
    logic                 lower_half_direction;
    logic                 upper_half_direction;
    logic                 lower_pullup_enable;
    logic                 upper_pullup_enable;
    logic                 port_irq_enable;
    logic                 port_low_level_irq_flag;
    logic                 lower_pullup_strength_select;
    logic                 upper_pullup_strength_select;
    logic                 pin6_timer_output_enable;
    logic                 pin7_timer_output_enable;
    npw_div_code_t        clock_divider_sel;
    npw_cko_state_t       cko_state;

    logic [`NPW_SYNC_BITS-1:0] sync_a;
    logic [`NPW_SYNC_BITS-1:0] sync_b;
    logic [`NPW_SYNC_BITS-1:0] sync_c;
    logic [`NPW_SYNC_BITS-1:0] sync_q;

    logic [DIV_WIDTH-1:0] div_cnt;
    logic                 src_prev;
    logic                 cko_prev;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic        bus_req;
    logic        bus_wr;
    logic [15:0] bus_idx;
    logic [7:0]  wdat;
    logic        wr_latch;
    logic        wr_raw;
    logic        wr_set;
    logic        wr_clr;
    logic        wr_inv;
    logic        wr_ctrl;
    logic        wr_alt;

    assign bus_req  = cyc_i & stb_i & ~ack_o;
    // writes land at the ack edge, where the master completes the cycle
    assign bus_wr   = cyc_i & stb_i & ack_o & we_i & sel_i[0];
    assign bus_idx  = adr_i[17:2];
    assign wdat     = dat_i[7:0];
    assign wr_latch = bus_wr & (bus_idx == `NPW_IDX_LATCH);
    assign wr_raw   = bus_wr & (bus_idx == `NPW_IDX_LATCH_RAW);
    assign wr_set   = bus_wr & (bus_idx == `NPW_IDX_LATCH_SET);
    assign wr_clr   = bus_wr & (bus_idx == `NPW_IDX_LATCH_CLR);
    assign wr_inv   = bus_wr & (bus_idx == `NPW_IDX_LATCH_INV);
    assign wr_ctrl  = bus_wr & (bus_idx == `NPW_IDX_CTRL);
    assign wr_alt   = bus_wr & (bus_idx == `NPW_IDX_ALT);

    // ----------------------------------------------------------------
    // input synchronisers: pins, source and subclock
    // ----------------------------------------------------------------
    logic [`NPW_SYNC_BITS-1:0] raw_in;
    logic [7:0]                pin_level;
    logic                      src_level;
    logic                      sub_level;

    assign raw_in    = {sub_osc_i, src_osc_i, pin_i};
    assign pin_level = sync_q[7:0];
    assign src_level = sync_q[8];
    assign sub_level = sync_q[9];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // a bit changes only once the second and third stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_q <= '0;
        end else begin
            sync_q <= (sync_b & sync_c) | (sync_q & (sync_b ^ sync_c));
        end
    end

    // ----------------------------------------------------------------
    // output latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_output_latch <= `NPW_RST_LATCH;
        end else if (wr_latch || wr_raw) begin
            port_output_latch <= wdat;
        end else if (wr_set) begin
            port_output_latch <= port_output_latch | wdat;
        end else if (wr_clr) begin
            port_output_latch <= port_output_latch & ~wdat;
        end else if (wr_inv) begin
            port_output_latch <= port_output_latch ^ wdat;
        end
    end

    // ----------------------------------------------------------------
    // direction, pull-up and enable bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lower_half_direction         <= 1'b0;
            upper_half_direction         <= 1'b0;
            lower_pullup_enable          <= 1'b0;
            upper_pullup_enable          <= 1'b0;
            port_irq_enable              <= 1'b0;
            lower_pullup_strength_select <= 1'b0;
            upper_pullup_strength_select <= 1'b0;
        end else if (wr_ctrl) begin
            lower_half_direction         <= wdat[`NPW_CTRL_LO_DIR];
            upper_half_direction         <= wdat[`NPW_CTRL_HI_DIR];
            lower_pullup_enable          <= wdat[`NPW_CTRL_LO_PU];
            upper_pullup_enable          <= wdat[`NPW_CTRL_HI_PU];
            port_irq_enable              <= wdat[`NPW_CTRL_IE];
            lower_pullup_strength_select <= wdat[`NPW_CTRL_LO_PUS];
            upper_pullup_strength_select <= wdat[`NPW_CTRL_HI_PUS];
        end
    end

    // ----------------------------------------------------------------
    // low-level wake flag
    // ----------------------------------------------------------------
    logic [7:0] in_mode;
    logic       low_seen;

    assign in_mode  = {{4{~upper_half_direction}}, {4{~lower_half_direction}}};
    // runs on every clock, standby included, so the release can be raised
    assign low_seen = |(in_mode & port_output_latch & ~pin_level);

    // a detection in the clearing cycle wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_low_level_irq_flag <= 1'b0;
        end else if (low_seen) begin
            port_low_level_irq_flag <= 1'b1;
        end else if (wr_ctrl) begin
            port_low_level_irq_flag <= wdat[`NPW_CTRL_FLAG];
        end
    end

    assign irq_o             = port_low_level_irq_flag & port_irq_enable;
    assign standby_release_o = port_low_level_irq_flag & port_irq_enable;
    assign irq_vector_o      = `NPW_IRQ_VECTOR;

    // ----------------------------------------------------------------
    // alternate output control
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin6_timer_output_enable <= 1'b0;
            pin7_timer_output_enable <= 1'b0;
            clock_divider_sel        <= 3'h0;
        end else if (wr_alt) begin
            pin6_timer_output_enable <= wdat[`NPW_ALT_PIN6_TIMER_OUTPUT_ENABLE];
            pin7_timer_output_enable <= wdat[`NPW_ALT_PIN7_TIMER_OUTPUT_ENABLE];
            clock_divider_sel        <= wdat[`NPW_ALT_DIV_MSB:`NPW_ALT_DIV_LSB];
        end
    end

    // ----------------------------------------------------------------
    // clock output divider
    // ----------------------------------------------------------------
    logic cko_level;
    logic cko_fall;
    logic cko_active;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev <= 1'b0;
            div_cnt  <= '0;
        end else begin
            src_prev <= src_level;
            if (src_level && !src_prev) begin
                div_cnt <= DIV_WIDTH'(div_cnt + 1'b1);
            end
        end
    end

    // counter bit n toggles every 2^n source periods, giving source over 2^(n+1)
    always_comb begin
        unique case (clock_divider_sel)
            3'h0: cko_level = src_level;
            3'h1: cko_level = div_cnt[0];
            3'h2: cko_level = div_cnt[1];
            3'h3: cko_level = div_cnt[2];
            3'h4: cko_level = div_cnt[3];
            3'h5: cko_level = div_cnt[4];
            3'h6: cko_level = div_cnt[5];
            3'h7: cko_level = sub_level;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cko_prev <= 1'b0;
        end else begin
            cko_prev <= cko_level;
        end
    end

    assign cko_fall   = cko_prev & ~cko_level;
    assign cko_active = (cko_state != NPW_CKO_OFF);

    // ----------------------------------------------------------------
    // clock output enable: clears only at the end of an output period
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cko_state <= NPW_CKO_OFF;
        end else begin
            unique case (cko_state)
                NPW_CKO_OFF: begin
                    if (wr_alt && wdat[`NPW_ALT_CKOEN]) begin
                        cko_state <= NPW_CKO_ON;
                    end
                end
                NPW_CKO_ON: begin
                    if (wr_alt && !wdat[`NPW_ALT_CKOEN]) begin
                        cko_state <= NPW_CKO_DRAIN;
                    end
                end
                NPW_CKO_DRAIN: begin
                    if (wr_alt && wdat[`NPW_ALT_CKOEN]) begin
                        cko_state <= NPW_CKO_ON;
                    end else if (cko_fall) begin
                        cko_state <= NPW_CKO_OFF;
                    end
                end
                default: begin
                    cko_state <= NPW_CKO_OFF;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive and pull-up selection
    // ----------------------------------------------------------------
    logic [7:0] out_mode;
    logic [7:0] out_val;
    logic [7:0] next_pin_o;
    logic [7:0] next_pin_oe;
    logic [7:0] next_pullup_en;
    logic [7:0] next_pullup_hiz;
    logic       hold_pins;

    assign out_mode = ~in_mode;

    always_comb begin
        out_val    = port_output_latch;
        out_val[7] = port_output_latch[7] | (pin7_timer_output_enable & timer7_toggle_i);
        out_val[6] = port_output_latch[6] | (pin6_timer_output_enable & timer6_toggle_i);
        out_val[5] = port_output_latch[5] | (cko_active & cko_level);
    end

    // push-pull pins drive both levels, open-drain pins only pull low
    assign next_pin_o  = out_val & CMOS_OPTION;
    assign next_pin_oe = out_mode & (CMOS_OPTION | ~out_val);

    assign next_pullup_en = CMOS_OPTION & in_mode &
                            {{4{upper_pullup_enable}}, {4{lower_pullup_enable}}};
    assign next_pullup_hiz = next_pullup_en &
                             {{4{upper_pullup_strength_select}},
                              {4{lower_pullup_strength_select}}};

    assign hold_pins = idle_i | standby_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o        <= 8'h00;
            pin_oe_o     <= 8'h00;
            pullup_en_o  <= 8'h00;
            pullup_hiz_o <= 8'h00;
        end else if (!hold_pins) begin
            pin_o        <= next_pin_o;
            pin_oe_o     <= next_pin_oe;
            pullup_en_o  <= next_pullup_en;
            pullup_hiz_o <= next_pullup_hiz;
        end
    end

    // ----------------------------------------------------------------
    // register read-back
    // ----------------------------------------------------------------
    logic [7:0] ctrl_rd;
    logic [7:0] alt_rd;
    logic [7:0] next_rd;

    always_comb begin
        ctrl_rd                      = 8'h00;
        ctrl_rd[`NPW_CTRL_LO_DIR]    = lower_half_direction;
        ctrl_rd[`NPW_CTRL_HI_DIR]    = upper_half_direction;
        ctrl_rd[`NPW_CTRL_LO_PU]     = lower_pullup_enable;
        ctrl_rd[`NPW_CTRL_HI_PU]     = upper_pullup_enable;
        ctrl_rd[`NPW_CTRL_IE]        = port_irq_enable;
        ctrl_rd[`NPW_CTRL_FLAG]      = port_low_level_irq_flag;
        ctrl_rd[`NPW_CTRL_LO_PUS]    = lower_pullup_strength_select;
        ctrl_rd[`NPW_CTRL_HI_PUS]    = upper_pullup_strength_select;
    end

    always_comb begin
        alt_rd                                   = 8'h00;
        alt_rd[`NPW_ALT_DIV_MSB:`NPW_ALT_DIV_LSB] = clock_divider_sel;
        alt_rd[`NPW_ALT_CKOEN]                   = cko_active;
        alt_rd[`NPW_ALT_PIN6_TIMER_OUTPUT_ENABLE]                    = pin6_timer_output_enable;
        alt_rd[`NPW_ALT_PIN7_TIMER_OUTPUT_ENABLE]                    = pin7_timer_output_enable;
    end

    always_comb begin
        unique case (bus_idx)
            `NPW_IDX_LATCH:     next_rd = pin_level;
            `NPW_IDX_LATCH_RAW: next_rd = port_output_latch;
            `NPW_IDX_CTRL:      next_rd = ctrl_rd;
            `NPW_IDX_ALT:       next_rd = alt_rd;
            default:            next_rd = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Wishbone answer: one wait state, every address acknowledged
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            dat_o <= {24'h00_0000, next_rd};
        end
    end

endmodule // npw_port

// [npw_port_properties.sv]
// Purpose: concurrent checks on the port's outputs
// Assumes: all pins use the push-pull option
// Notes:   bound to npw_port below
`timescale 1ns/1ps
module npw_port_properties (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       idle_i,
    input wire logic       standby_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic [7:0] pullup_en_o,
    input wire logic       irq_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic       standby_release_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
        else $error("ack without request");
    a_vector_fixed: assert property (irq_vector_o == 8'h4b)
        else $error("wrong vector");
    a_release_irq: assert property (standby_release_o == irq_o)
        else $error("release differs from irq");
    a_upper_dir: assert property (pin_oe_o[7:4] inside {4'h0, 4'hf})
        else $error("upper half split");
    a_lower_dir: assert property (pin_oe_o[3:0] inside {4'h0, 4'hf})
        else $error("lower half split");
    a_pullup_input: assert property ((pullup_en_o & pin_oe_o) == 8'h00)
        else $error("pull-up on output pin");
    a_freeze_hold: assert property ((idle_i || standby_i) [*2] |=>
        $stable(pin_o) && $stable(pin_oe_o)) else $error("pins moved while frozen");
endmodule // npw_port_properties

bind npw_port npw_port_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .idle_i(idle_i),
    .standby_i(standby_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pullup_en_o(pullup_en_o), .irq_o(irq_o), .irq_vector_o(irq_vector_o),
    .standby_release_o(standby_release_o));

// [npw_port_regs.svh]
// Purpose: register indices, field positions, reset values and bit counts of the port
// Assumes: register indices are word indices; the byte address is four times the index
// Notes:   definitions only
`ifndef NPW_PORT_REGS_SVH
`define NPW_PORT_REGS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define NPW_IDX_LATCH        16'hfe40
`define NPW_IDX_CTRL         16'hfe41
`define NPW_IDX_ALT          16'hfe42
`define NPW_IDX_LATCH_RAW    16'hfe48
`define NPW_IDX_LATCH_SET    16'hfe49
`define NPW_IDX_LATCH_CLR    16'hfe4a
`define NPW_IDX_LATCH_INV    16'hfe4b

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define NPW_CTRL_LO_DIR      0
`define NPW_CTRL_HI_DIR      1
`define NPW_CTRL_LO_PU       2
`define NPW_CTRL_HI_PU       3
`define NPW_CTRL_IE          4
`define NPW_CTRL_FLAG        5
`define NPW_CTRL_LO_PUS      6
`define NPW_CTRL_HI_PUS      7

// ----------------------------------------------------------------
// alternate output register fields
// ----------------------------------------------------------------
`define NPW_ALT_DIV_LSB      0
`define NPW_ALT_DIV_MSB      2
`define NPW_ALT_CKOEN        3
`define NPW_ALT_PIN6_TIMER_OUTPUT_ENABLE         6
`define NPW_ALT_PIN7_TIMER_OUTPUT_ENABLE         7

// ----------------------------------------------------------------
// reset values, fixed values and counts
// ----------------------------------------------------------------
`define NPW_RST_LATCH        8'h00
`define NPW_RST_CTRL         8'h00
`define NPW_RST_ALT          8'h00
`define NPW_IRQ_VECTOR       8'h4b
`define NPW_DIV_BITS         6
`define NPW_SYNC_BITS        10

`endif

// [npw_tb.sv]
// Purpose: self-checking bench for npw_port
// Assumes: register indices and bus timing of the port header
// Notes:   src period 16 cycles, subclock period 64 cycles
`timescale 1ns/1ps
`include "npw_port_regs.svh"
module testbench;
    import npw_pkg::*;
    localparam logic [15:0] LAT = `NPW_IDX_LATCH, CTL = `NPW_IDX_CTRL, ALT = `NPW_IDX_ALT;
    localparam logic [15:0] RAW = `NPW_IDX_LATCH_RAW;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o, rel;
    logic t6 = 0, t7 = 0, src = 0, sub = 0, idle_i = 0, standby_i = 0;
    logic [17:0] adr_i = 0;
    logic [31:0] dat_i = 0, dat_o;
    logic [7:0] pin_i, pin_o, oe, pu, hiz, vec, ext_en = 0, ext_val = 0, rv;
    logic [5:0] oc = 0;
    int err_count = 0, checks_done = 0;
    npw_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(oe), .pullup_en_o(pu),
        .pullup_hiz_o(hiz), .timer6_toggle_i(t6), .timer7_toggle_i(t7), .src_osc_i(src),
        .sub_osc_i(sub), .idle_i(idle_i), .standby_i(standby_i), .irq_o(irq_o),
        .irq_vector_o(vec), .standby_release_o(rel));
    npw_pins_model u_pins (.clk_i(clk_i), .drv_i(pin_o), .oe_i(oe), .pu_i(pu),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        oc <= oc + 6'h01;
        src <= oc[3];
        sub <= oc[5];
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rv = dat_o[7:0];
        if (n >= 20) err_count++;
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input string nm, input logic [15:0] idx, input logic [7:0] e);
        wb(0, idx, 8'h00);
        chk(nm, e, rv);
    endtask
    task automatic t_reset();
        chk("oe", 8'h00, oe);
        rdc("ctrl", CTL, 8'h00);
        rdc("alt", ALT, 8'h00);
        rdc("raw", RAW, 8'h00);
        wb(1, 16'hfe50, 8'hff);
        rdc("unmapped", 16'hfe50, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_out();
        ext_en <= 8'h0f;
        ext_val <= 8'h06;
        wb(1, LAT, 8'ha5);
        wb(1, CTL, 8'h03);
        tick(4);
        chk("pins", 8'ha5, pin_o);
        chk("oe", 8'hff, oe);
        rdc("pin read", LAT, 8'ha5);
        wb(1, CTL, 8'h02);
        tick(6);
        chk("oe", 8'hf0, oe);
        rdc("pin read", LAT, 8'ha6);
        wb(1, `NPW_IDX_LATCH_SET, 8'h08);
        rdc("raw", RAW, 8'had);
        wb(1, `NPW_IDX_LATCH_CLR, 8'h01);
        wb(1, `NPW_IDX_LATCH_INV, 8'hf0);
        rdc("raw", RAW, 8'h5c);
        tick(2);
        rdc("pin read", LAT, 8'h56);
        $display("test output done");
    endtask
    task automatic t_pull();
        wb(1, CTL, 8'h4c);
        tick(2);
        chk("pullup", 8'hff, pu);
        chk("hiz", 8'h0f, hiz & pu);
        wb(1, CTL, 8'h8d);
        tick(2);
        chk("pullup", 8'hf0, pu);
        chk("hiz", 8'hf0, hiz & pu);
        $display("test pullup done");
    endtask
    task automatic t_irq();
        ext_en <= 8'hff;
        ext_val <= 8'hf7;
        wb(1, RAW, 8'h04);
        wb(1, CTL, 8'h10);
        tick(8);
        chk("irq", 8'h00, {7'h0, irq_o});
        standby_i <= 1;
        ext_val <= 8'hf3;
        tick(8);
        chk("release", 8'h01, {7'h0, rel});
        standby_i <= 0;
        ext_val <= 8'hff;
        tick(8);
        chk("irq", 8'h01, {7'h0, irq_o});
        rdc("flag", CTL, 8'h30);
        wb(1, CTL, 8'h10);
        tick(2);
        chk("irq", 8'h00, {7'h0, irq_o});
        wb(1, CTL, 8'h20);
        tick(2);
        chk("masked", 8'h00, {7'h0, irq_o});
        chk("vector", 8'h4b, vec);
        $display("test irq done");
    endtask
    task automatic t_alt();
        int n, k, e;
        logic p;
        ext_en <= 8'h00;
        wb(1, RAW, 8'h00);
        wb(1, CTL, 8'h03);
        wb(1, ALT, 8'hc0);
        t6 <= 1;
        t7 <= 1;
        tick(2);
        chk("timer", 8'hc0, pin_o);
        wb(1, CTL, 8'h01);
        tick(2);
        chk("oe", 8'h0f, oe);
        t6 <= 0;
        t7 <= 0;
        wb(1, CTL, 8'h03);
        for (int c = 0; c < 8; c++) begin
            wb(1, ALT, c[7:0]);
            wb(1, ALT, c[7:0] | 8'h08);
            n = 0;
            p = 1;
            repeat (1024) begin
                @(posedge clk_i);
                if (pin_o[5] && !p) n++;
                p = pin_o[5];
            end
            e = (c == 7) ? 16 : 64 >> c;
            chk("rises", 8'h01, {7'h0, n >= e - 1 && n <= e + 1});
            wb(1, ALT, c[7:0]);
            k = 0;
            do begin
                wb(0, ALT, 8'h00);
                k++;
            end while (rv[3] !== 1'b0 && k < 400);
            chk("enable", 8'h00, rv & 8'h08);
            tick(2);
            chk("pin5", 8'h00, {7'h0, pin_o[5]});
        end
        $display("test alternate done");
    endtask
    task automatic t_freeze();
        idle_i <= 1;
        wb(1, RAW, 8'hff);
        tick(3);
        chk("frozen", 8'h00, pin_o);
        idle_i <= 0;
        tick(3);
        chk("thawed", 8'hff, pin_o);
        $display("test freeze done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        tick(5);
        rst_i <= 0;
        t_reset();
        t_out();
        t_pull();
        t_irq();
        t_alt();
        t_freeze();
        results();
    end
endmodule // testbench
